/* verilog/spk_packer.sv */
// Purpose: packs serial bytes into network frames and fans them out to up to four hosts
// Assumes: serial and network side logic run on pclk; registers over apb
// Notes:
// Notes on behaviour
// R01 - frame length zero: no length limit, close on marker, timeout or full buffer
// R02 - frame length 1..1024: close frame when byte count reaches it
// R03 - two marker bytes 00..FF; first then second character of the sequence
// R04 - no markers defined: every received byte is forwarded at once
// R05 - markers defined: hold bytes until marker or marker pair, then send
// R06 - both markers zero disable marker framing; only first nonzero matches alone
// R07 - buffer full before marker: pack the data and empty the buffer
// R08 - marker framing needs a nonzero first marker
// R09 - post-marker handling only with first marker; pair must complete first
// R10 - plain option: send buffer including marker when the match completes
// R11 - plus-one or plus-two: send after one or two further bytes, included
// R12 - strip option: drop marker bytes and send the rest
// R13 - flush timeout zero disables the idle flush
// R14 - flush timeout 1..65535 ms: no next byte in time packs buffer
// R15 - software should set flush timeout above one character time
// R16 - with several hosts all share the stored serial settings
// R17 - skipping off: wait until every host took the byte before the next
// R18 - skipping on: drop a stalled host and serve the others
// R19 - skipping defaults off and acts only with more than one host
// R20 - driver commands ignored when disabled; latest command wins; multi-host only
// R21 - connection idle check 0..99 min, default 7; zero never closes
// R22 - listen on port 1..65535, default 4001; hosts must use it
// R23 - host connection count 1..4; that many hosts may connect at once
// R24 - flush timer restarts per byte, counts ms ticks, idle while frame empty
module spk_packer
    import spk_pkg::*;
#(
    parameter int BUF_AW = 10,
    parameter int MS_DIV = MS_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output spk_pkg::spk_net_type net_out,
    output logic [3:0] net_host_mask,
    input wire logic [3:0] net_ack,
    input wire logic [3:0] host_stall,
    input wire logic conn_req,
    input wire logic [15:0] conn_port,
    output logic conn_grant,
    output logic [1:0] conn_slot,
    output logic [3:0] host_connected,
    input wire logic [3:0] host_drop,
    input wire logic [3:0] host_activity,
    output logic [3:0] host_idle_close,
    input wire logic [3:0] cmd_valid,
    input wire logic [7:0] cmd_data,
    output logic [7:0] ctrl_cmd,
    output logic ctrl_cmd_strobe
);
    import spk_pkg::*;
    localparam int PW = BUF_AW + 1;
    localparam int DEPTH = 1 << BUF_AW;
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [15:0] spk_clamp(input logic [15:0] v, input logic [15:0] lo,
                                              input logic [15:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : spk_clamp
    function automatic logic [2:0] spk_count(input logic [3:0] m);
        return 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
    endfunction : spk_count
    function automatic logic [1:0] spk_first(input logic [3:0] m);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (m[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction : spk_first
    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    spk_cfg_type cfg;  // one stored setting set serves every host, see R16
    logic [7:0] last_cmd;
    logic [1:0] last_cmd_host;
    logic [PW-1:0] wr_ptr, cm_ptr, rd_ptr;
    spk_drain_type drain;
    wire apb_setup = psel & ~penable;
    wire apb_write = psel & penable & pready & pwrite;
    wire sel_ctrl = paddr == OFF_CTRL;
    wire sel_len = paddr == OFF_FRAME_LEN;
    wire sel_mark = paddr == OFF_MARKER;
    wire sel_flush = paddr == OFF_FLUSH;
    wire sel_idle = paddr == OFF_IDLE;
    wire sel_port = paddr == OFF_PORT;
    wire sel_stat = paddr == OFF_STATUS;
    wire sel_cmd = paddr == OFF_CMD;
    wire mapped = sel_ctrl | sel_len | sel_mark | sel_flush | sel_idle | sel_port | sel_stat
        | sel_cmd;
    wire [PW-1:0] occupancy = wr_ptr - rd_ptr;
    wire [31:0] next_prdata =
        sel_ctrl ? 32'({cfg.post, cfg.drv_en, cfg.skip_stalled_host, cfg.max_conn}) :
        sel_len ? 32'(cfg.frame_len) :
        sel_mark ? 32'({cfg.marker2, cfg.marker1}) :
        sel_flush ? 32'(cfg.flush_ms) :
        sel_idle ? 32'(cfg.connection_idle_check) :
        sel_port ? 32'(cfg.listen_port_number) :
        sel_stat ? 32'({16'(occupancy), host_connected, 2'h0, drain, rx_ready}) :
        sel_cmd ? 32'({last_cmd_host, last_cmd}) : 32'h0000_0000;
    // writes clamp to the legal ranges; port zero is refused and keeps the old value
    wire [15:0] w_conn = spk_clamp(16'(pwdata[CTRL_CONN_LSB +: 3]), 16'h0001, 16'(MAX_HOSTS));
    wire [15:0] w_len = spk_clamp(pwdata[15:0], 16'h0000, 16'(MAX_FRAME_LEN));
    wire [15:0] w_idle = spk_clamp(pwdata[15:0], 16'h0000, 16'(MAX_IDLE_MIN));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~mapped;
            prdata <= apb_setup ? next_prdata : 32'h0000_0000;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= '{max_conn: RST_MAX_CONN, skip_stalled_host: 1'b0, drv_en: 1'b1,
                     post: PM_PLAIN, frame_len: 11'h000, marker1: 8'h00, marker2: 8'h00,
                     flush_ms: 16'h0000, connection_idle_check: RST_IDLE_MIN,
                     listen_port_number: RST_PORT};  // see R19 see R21 see R22
        end else if (apb_write) begin
            if (sel_ctrl) begin
                cfg.max_conn <= w_conn[2:0];  // see R23
                cfg.skip_stalled_host <= pwdata[CTRL_SKIP_BIT];
                cfg.drv_en <= pwdata[CTRL_DRV_BIT];
                cfg.post <= spk_post_type'(pwdata[CTRL_POST_LSB +: 2]);
            end
            if (sel_len) begin
                cfg.frame_len <= w_len[10:0];
            end
            if (sel_mark) begin
                cfg.marker1 <= pwdata[7:0];  // see R03
                cfg.marker2 <= pwdata[MARKER2_LSB +: 8];
            end
            if (sel_flush) begin
                cfg.flush_ms <= pwdata[15:0];
            end
            if (sel_idle) begin
                cfg.connection_idle_check <= w_idle[6:0];
            end
            if (sel_port && pwdata[15:0] != 16'h0000) begin
                cfg.listen_port_number <= pwdata[15:0];
            end
        end
    end
    // ------------------------------------------------------------
    // framing
    // ------------------------------------------------------------
    logic [7:0] buf_mem [DEPTH];
    logic end_mem [DEPTH];
    logic [1:0] post_cnt;
    logic prev_m1;
    logic [15:0] flush_pre, flush_cnt;
    logic flush_hit;
    logic [PW-1:0] next_rd;
    wire rx_accept = rx_valid & rx_ready;
    wire markers_on = cfg.marker1 != 8'h00;  // see R06 see R08
    wire two_mark = markers_on & (cfg.marker2 != 8'h00);
    wire match_raw = two_mark ? (prev_m1 & (rx_data == cfg.marker2)) : (rx_data == cfg.marker1);
    wire match = rx_accept & markers_on & match_raw & (post_cnt == 2'h0);  // see R09
    wire strip = match & (cfg.post == PM_STRIP);
    wire write_byte = rx_accept & ~strip;
    // strip of a pair takes back the first marker already stored
    wire [PW-1:0] next_wr = (strip & two_mark) ? wr_ptr - PW'(1) :
        write_byte ? wr_ptr + PW'(1) : wr_ptr;  // see R12
    wire [PW-1:0] fill_after = next_wr - cm_ptr;
    wire [PW-1:0] frame_fill = wr_ptr - cm_ptr;
    wire c_post = rx_accept & (post_cnt == 2'h1);  // see R11
    wire c_match = match & ((cfg.post == PM_PLAIN) | (cfg.post == PM_STRIP));  // see R10
    wire c_plain = rx_accept & ~markers_on;  // see R04
    wire c_len = rx_accept & (cfg.frame_len != 11'h000)
        & (16'(fill_after) >= 16'(cfg.frame_len));  // see R01 see R02
    wire c_full = rx_accept & ((next_wr - rd_ptr) == PW'(DEPTH));  // see R07
    wire commit = c_post | c_match | c_plain | c_len | c_full | flush_hit;  // see R05
    wire mark_end = commit & (fill_after != PW'(0));
    wire [1:0] next_post = flush_hit ? 2'h0 :
        (rx_accept & post_cnt != 2'h0) ? post_cnt - 2'h1 :
        (match & cfg.post == PM_PLUS1) ? 2'h1 :
        (match & cfg.post == PM_PLUS2) ? 2'h2 : post_cnt;
    wire [PW-1:0] next_occ = next_wr - next_rd;
    always_ff @(posedge pclk) begin
        if (write_byte) begin
            buf_mem[wr_ptr[BUF_AW-1:0]] <= rx_data;
        end
        if (mark_end | write_byte) begin
            end_mem[mark_end ? (next_wr[BUF_AW-1:0] - BUF_AW'(1)) : wr_ptr[BUF_AW-1:0]]
                <= mark_end;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            cm_ptr <= '0;
            post_cnt <= 2'h0;
            prev_m1 <= 1'b0;
            rx_ready <= 1'b1;
        end else begin
            wr_ptr <= next_wr;
            cm_ptr <= commit ? next_wr : cm_ptr;
            post_cnt <= next_post;
            prev_m1 <= commit ? 1'b0 : (rx_accept ? (rx_data == cfg.marker1) & ~strip : prev_m1);
            rx_ready <= ~next_occ[BUF_AW];  // full buffer back-pressures the serial side
        end
    end
    // ------------------------------------------------------------
    // idle flush timer
    // ------------------------------------------------------------
    // prescaler restarts with each byte so the wait is never shorter than set
    wire flush_run = (cfg.flush_ms != 16'h0000) & (frame_fill != PW'(0)) & ~rx_accept;
    wire ms_tick = flush_pre == 16'(MS_DIV - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_pre <= 16'h0000;
            flush_cnt <= 16'h0000;
            flush_hit <= 1'b0;
        end else begin
            flush_pre <= (!flush_run || ms_tick) ? 16'h0000 : flush_pre + 16'h0001;  // see R24
            flush_cnt <= !flush_run ? 16'h0000 : flush_cnt + 16'(ms_tick);
            flush_hit <= flush_run & ms_tick & ~flush_hit
                & (flush_cnt + 16'h0001 >= cfg.flush_ms);  // see R13 see R14
        end
    end
    // ------------------------------------------------------------
    // fan-out to hosts
    // ------------------------------------------------------------
    logic [3:0] pend;
    wire multi = cfg.max_conn > 3'h1;
    wire skip_eff = cfg.skip_stalled_host & multi;  // see R19
    wire [3:0] still_wait = pend & ~net_ack & host_connected
        & ~(skip_eff ? host_stall : 4'h0);  // see R17 see R18
    wire have_byte = rd_ptr != cm_ptr;
    wire load = (drain == DR_IDLE) & have_byte & (host_connected != 4'h0);
    wire done = (drain == DR_SEND) & (still_wait == 4'h0);
    // with nobody connected committed bytes are dropped rather than blocking the serial side
    wire discard = (drain == DR_IDLE) & have_byte & (host_connected == 4'h0);
    assign next_rd = (done | discard) ? rd_ptr + PW'(1) : rd_ptr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drain <= DR_IDLE;
            rd_ptr <= '0;
            pend <= 4'h0;
            net_out.valid <= 1'b0;
            net_out.last <= 1'b0;
            net_out.data <= 8'h00;
            net_host_mask <= 4'h0;
        end else begin
            if (load) begin
                net_out.data <= buf_mem[rd_ptr[BUF_AW-1:0]];
                net_out.last <= end_mem[rd_ptr[BUF_AW-1:0]];
            end
            rd_ptr <= next_rd;
            unique case (drain)
                DR_IDLE: begin
                    drain <= load ? DR_SEND : DR_IDLE;
                    pend <= host_connected;
                end
                DR_SEND: begin
                    drain <= done ? DR_IDLE : DR_SEND;
                    pend <= still_wait;
                end
            endcase
            net_out.valid <= load | ((drain == DR_SEND) & ~done);
            net_host_mask <= load ? host_connected : still_wait;
        end
    end
    // ------------------------------------------------------------
    // connections, idle check and driver commands
    // ------------------------------------------------------------
    logic [15:0] min_pre, min_cnt;
    logic [6:0] idle_min [4];
    wire min_ms = min_pre == 16'(MS_DIV - 1);
    wire min_tick = min_ms & (min_cnt == MS_PER_MIN - 16'h0001);
    wire [3:0] free = ~host_connected;
    wire grant_ok = conn_req & (conn_port == cfg.listen_port_number)
        & (spk_count(host_connected) < cfg.max_conn) & (free != 4'h0);  // see R22 see R23
    wire [3:0] grant_mask = grant_ok ? (4'h1 << spk_first(free)) : 4'h0;
    wire [3:0] cmd_ok = cmd_valid & host_connected & {4{cfg.drv_en | ~multi}};  // see R20
    logic [3:0] idle_hit;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            idle_hit[i] = host_connected[i] & min_tick & ~host_activity[i]
                & (cfg.connection_idle_check != 7'h00)
                & (idle_min[i] + 7'h01 >= cfg.connection_idle_check);  // see R21
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            min_pre <= 16'h0000;
            min_cnt <= 16'h0000;
            idle_min <= '{default: 7'h00};
            host_connected <= 4'h0;
            host_idle_close <= 4'h0;
            conn_grant <= 1'b0;
            conn_slot <= 2'h0;
        end else begin
            min_pre <= min_ms ? 16'h0000 : min_pre + 16'h0001;
            min_cnt <= min_tick ? 16'h0000 : min_cnt + 16'(min_ms);
            for (int i = 0; i < 4; i++) begin
                idle_min[i] <= (host_activity[i] | grant_mask[i] | ~host_connected[i])
                    ? 7'h00 : idle_min[i] + 7'(min_tick);
            end
            host_connected <= (host_connected & ~host_drop & ~idle_hit) | grant_mask;
            host_idle_close <= idle_hit;
            conn_grant <= grant_ok;
            conn_slot <= grant_ok ? spk_first(free) : conn_slot;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_cmd <= 8'h00;
            ctrl_cmd_strobe <= 1'b0;
            last_cmd <= 8'h00;
            last_cmd_host <= 2'h0;
        end else begin
            ctrl_cmd <= (cmd_ok != 4'h0) ? cmd_data : ctrl_cmd;
            ctrl_cmd_strobe <= cmd_ok != 4'h0;
            last_cmd <= (cmd_ok != 4'h0) ? cmd_data : last_cmd;
            last_cmd_host <= (cmd_ok != 4'h0) ? spk_first(cmd_ok) : last_cmd_host;
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_len_close;
        c_len |=> (cm_ptr == wr_ptr) && (post_cnt == $past(next_post));
    endproperty
    a_len_close: assert property (p_len_close) else $error("length limit left open"); // see R02
    property p_plain_fwd;
        (rx_accept && !markers_on) |=> cm_ptr == wr_ptr;
    endproperty
    a_plain_fwd: assert property (p_plain_fwd) else $error("byte held, no markers"); // see R04
    property p_hold;
        (rx_accept && markers_on && !match && post_cnt == 2'h0 && !c_len && !c_full
            && !flush_hit) |=> cm_ptr == $past(cm_ptr);
    endproperty
    a_hold: assert property (p_hold) else $error("frame closed without cause"); // see R05
    property p_full;
        occupancy == PW'(DEPTH) |-> (cm_ptr == wr_ptr) && !rx_ready;
    endproperty
    a_full: assert property (p_full) else $error("full buffer not packed"); // see R07
    property p_plus2;
        (match && cfg.post == PM_PLUS2) |=> post_cnt == 2'h2 ##0 cm_ptr == $past(cm_ptr);
    endproperty
    a_plus2: assert property (p_plus2) else $error("plus-two sent early"); // see R11
    property p_strip;
        (match && cfg.post == PM_STRIP && !two_mark) |=> wr_ptr == $past(wr_ptr)
            && cm_ptr == wr_ptr;
    endproperty
    a_strip: assert property (p_strip) else $error("marker not stripped"); // see R12
    property p_flush_off;
        cfg.flush_ms == 16'h0000 |=> !flush_hit;
    endproperty
    a_flush_off: assert property (p_flush_off) else $error("flush with timeout off"); // see R13
    property p_wait_all;
        (drain == DR_SEND && still_wait != 4'h0) |=> drain == DR_SEND
            && rd_ptr == $past(rd_ptr) && net_out.valid;
    endproperty
    a_wait_all: assert property (p_wait_all) else $error("byte left before all hosts"); // see R17
    property p_drv_off;
        ctrl_cmd_strobe |-> $past(cfg.drv_en || cfg.max_conn == 3'h1);
    endproperty
    a_drv_off: assert property (p_drv_off) else $error("command taken when off"); // see R20
    property p_port;
        conn_grant |-> $past(conn_port == cfg.listen_port_number)
            ##1 (!conn_grant || $past(conn_req));
    endproperty
    a_port: assert property (p_port) else $error("grant on wrong port"); // see R22
endmodule : spk_packer

/* verilog/spk_pkg.sv */
// Purpose: shared constants and types of the serial-to-network packer
// Assumes: apb at 20 MHz, 32-bit data, word-aligned registers
// Notes: register reset values follow the factory defaults
package spk_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FRAME_LEN = 8'h04;
    localparam logic [7:0] OFF_MARKER = 8'h08;
    localparam logic [7:0] OFF_FLUSH = 8'h0C;
    localparam logic [7:0] OFF_IDLE = 8'h10;
    localparam logic [7:0] OFF_PORT = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_CMD = 8'h1C;
    localparam int CTRL_CONN_LSB = 0;
    localparam int CTRL_SKIP_BIT = 3;
    localparam int CTRL_DRV_BIT = 4;
    localparam int CTRL_POST_LSB = 5;
    localparam int MARKER2_LSB = 8;
    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [2:0] RST_MAX_CONN = 3'h1;
    localparam logic [2:0] MAX_HOSTS = 3'h4;
    localparam logic [10:0] MAX_FRAME_LEN = 11'h400;
    localparam logic [6:0] RST_IDLE_MIN = 7'h07;
    localparam logic [6:0] MAX_IDLE_MIN = 7'h63;
    localparam logic [15:0] RST_PORT = 16'h0FA1;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_MS = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [15:0] MS_PER_MIN = 16'hEA60;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PM_PLAIN = 2'b00,
        PM_PLUS1 = 2'b01,
        PM_PLUS2 = 2'b10,
        PM_STRIP = 2'b11
    } spk_post_type;
    typedef enum logic {
        DR_IDLE = 1'b0,
        DR_SEND = 1'b1
    } spk_drain_type;
    typedef struct packed {
        logic [2:0] max_conn;
        logic skip_stalled_host;
        logic drv_en;
        spk_post_type post;
        logic [10:0] frame_len;
        logic [7:0] marker1;
        logic [7:0] marker2;
        logic [15:0] flush_ms;
        logic [6:0] connection_idle_check;
        logic [15:0] listen_port_number;
    } spk_cfg_type;
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } spk_net_type;
endpackage : spk_pkg

/* testbench/spk_host_model.sv */
// Purpose: remote host model that accepts network bytes from the packer
// Assumes: one byte owed per host at a time, acks are one-cycle pulses
// Notes: a slow host only acks on every other cycle
module spk_host_model
    import spk_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire spk_pkg::spk_net_type net_out,
    input wire logic [3:0] net_host_mask,
    input wire logic slow,
    input wire logic [3:0] stall,
    output logic [3:0] net_ack
);
    logic pace;
    // every host takes the same byte stream, no settings of its own
    // ack only a byte still owed, never twice for one byte; a stalled host stays mute
    wire [3:0] owed = net_host_mask & ~net_ack & ~stall;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            net_ack <= 4'h0;
            pace <= 1'b0;
        end else begin
            pace <= !pace;
            net_ack <= (net_out.valid && (!slow || pace)) ? owed : 4'h0;
        end
    end
endmodule : spk_host_model

/* testbench/tb_top.sv */
// Purpose: self-checking bench of the packer over apb and serial input
// Assumes: hosts connect on slots 0 and 1, millisecond shortened to 4 cycles
// Notes: bytes are collected when host 0 acks them
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import spk_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_valid, rx_ready;
    logic conn_req, slow, ctrl_cmd_strobe;
    logic [1:0] conn_slot;
    logic [7:0] paddr, rx_data, cmd_data, ctrl_cmd;
    logic [31:0] pwdata, prdata;
    logic [3:0] net_host_mask, net_ack, host_connected, cmd_valid, stall;
    logic [15:0] conn_port;
    spk_net_type net_out;
    logic [8:0] got[$];
    int fails = 0;
    int check_count = 0;
    spk_packer #(.MS_DIV(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .net_out(net_out), .net_host_mask(net_host_mask),
        .net_ack(net_ack), .host_stall(stall), .conn_req(conn_req), .conn_port(conn_port),
        .conn_grant(), .conn_slot(conn_slot), .host_connected(host_connected),
        .host_drop(4'h0), .host_activity(4'h0), .host_idle_close(), .cmd_valid(cmd_valid),
        .cmd_data(cmd_data), .ctrl_cmd(ctrl_cmd), .ctrl_cmd_strobe(ctrl_cmd_strobe));
    spk_host_model host (.pclk(pclk), .presetn(presetn), .net_out(net_out),
        .net_host_mask(net_host_mask), .slow(slow), .stall(stall), .net_ack(net_ack));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = !pclk;
    end
    always @(posedge pclk) if (net_ack[0] && net_out.valid)
        got.push_back({net_out.last, net_out.data});
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // holds the whole request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [32:0] q);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] q;
        apb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        logic [32:0] q;
        apb(1'b0, a, 32'h0, q);
        chk("register read", e[31:0], q[31:0]);
        chk("slave error", {31'h0, e[32]}, {31'h0, q[32]});
    endtask : rd
    task automatic conn(input logic [15:0] p, input logic [3:0] e);
        conn_port <= p;
        conn_req <= 1'b1;
        @(posedge pclk);
        conn_req <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("host connected", {28'h0, e}, {28'h0, host_connected});
    endtask : conn
    task automatic send(input logic [7:0] q[$]);
        foreach (q[i]) begin
            rx_valid <= 1'b1;
            rx_data <= q[i];
            @(posedge pclk);
        end
        rx_valid <= 1'b0;
        @(posedge pclk);
    endtask : send
    task automatic frame(input logic [8:0] e[$]);
        repeat (60) @(posedge pclk);
        chk("frame length", e.size(), got.size());
        foreach (e[i]) if (i < got.size()) chk("frame byte", {23'h0, e[i]}, {23'h0, got[i]});
        got.delete();
    endtask : frame
    // strobe stands one cycle: looked at on the edge after the one that takes the command
    task automatic cmd(input logic [7:0] d, input logic s);
        cmd_data <= d;
        cmd_valid <= 4'h1;
        @(posedge pclk);
        cmd_valid <= 4'h0;
        @(posedge pclk);
        chk("command strobe", {31'h0, s}, {31'h0, ctrl_cmd_strobe});
        repeat (2) @(posedge pclk);
    endtask : cmd
    initial begin
        {presetn, psel, penable, pwrite, rx_valid, conn_req, slow} = 7'h0;
        {paddr, rx_data, cmd_data, pwdata, cmd_valid, conn_port, stall} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFF_CTRL, 33'h11);
        rd(OFF_IDLE, 33'h7);
        rd(OFF_FRAME_LEN, 33'h0);
        rd(OFF_FLUSH, 33'h0);
        rd(8'h40, 33'h1_0000_0000); // unmapped place answers with an error
        wr(OFF_PORT, 32'h0);
        rd(OFF_PORT, 33'h0FA1);
        conn(16'h04D2, 4'h0);
        conn(16'h0FA1, 4'h1);
        slow <= 1'b1;
        send('{8'h41, 8'h42});
        frame('{9'h141, 9'h142});
        wr(OFF_MARKER, 32'h0D);
        send('{8'h41, 8'h42, 8'h0D});
        frame('{9'h041, 9'h042, 9'h10D});
        wr(OFF_CTRL, 32'h71);
        send('{8'h41, 8'h42, 8'h0D});
        frame('{9'h041, 9'h142});
        wr(OFF_CTRL, 32'h51);
        send('{8'h41, 8'h0D, 8'h42, 8'h43});
        frame('{9'h041, 9'h00D, 9'h042, 9'h143});
        wr(OFF_CTRL, 32'h31);
        send('{8'h41, 8'h0D, 8'h42});
        frame('{9'h041, 9'h00D, 9'h142});
        wr(OFF_CTRL, 32'h11);
        wr(OFF_MARKER, 32'h0A0D);
        send('{8'h0D, 8'h41, 8'h0D, 8'h0A});
        frame('{9'h00D, 9'h041, 9'h00D, 9'h10A});
        wr(OFF_FRAME_LEN, 32'h2);
        wr(OFF_FLUSH, 32'h2);
        send('{8'h41, 8'h42, 8'h43});
        frame('{9'h041, 9'h142, 9'h143});
        cmd(8'h5A, 1'b1);
        chk("command", 32'h5A, {24'h0, ctrl_cmd});
        rd(OFF_CMD, 33'h05A);
        wr(OFF_CTRL, 32'h0A);
        conn(16'h0FA1, 4'h3);
        chk("grant slot", 32'h1, {30'h0, conn_slot});
        stall <= 4'h2;
        send('{8'h44});
        frame('{9'h144});
        wr(OFF_CTRL, 32'h02);
        send('{8'h45});
        repeat (60) @(posedge pclk);
        chk("byte still offered", 32'h1, {31'h0, net_out.valid});
        chk("hosts still owed", 32'h2, {28'h0, net_host_mask});
        stall <= 4'h0;
        frame('{9'h145});
        cmd(8'hA5, 1'b0);
        chk("command", 32'h5A, {24'h0, ctrl_cmd});
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        end_of_test();
    end
endmodule : tb_top
